/* hdl/alarm_params.svh */
// Purpose: constants for the limit alarm evaluator
// Assumes: 250 MHz mclk, scan tick supplied as one-cycle enable
// Notes:   times given in their own units, counts derived
`ifndef ALARM_PARAMS_SVH
`define ALARM_PARAMS_SVH
`define MCLK_HZ            250000000
`define SLOPE_WINDOW_S     30
`define SECONDS_PER_MIN    60
`define ACT_NONE           4'h0
`define ACT_HIGH           4'h1
`define ACT_LOW            4'h2
`define ACT_OFFSET_BAND    4'h3
`define ACT_UPPER_OFFSET   4'h4
`define ACT_LOWER_OFFSET   4'h5
`define ACT_RISING_SLOPE   4'h6
`define ACT_FALLING_SLOPE  4'h7
`define PULSE_SCANS        1
`endif

/* hdl/alarm_pkg.sv */
// Purpose: types for the limit alarm evaluator
// Assumes: alarm_params.svh supplies encodings
// Notes:   action codes mirror the header macros
`default_nettype none
`include "alarm_params.svh"
package alarm_pkg;
  typedef enum logic [3:0] {
    act_none          = `ACT_NONE,
    act_high          = `ACT_HIGH,
    act_low           = `ACT_LOW,
    offset_band_mode  = `ACT_OFFSET_BAND,
    upper_offset_mode = `ACT_UPPER_OFFSET,
    lower_offset_mode = `ACT_LOWER_OFFSET,
    rising_slope_mode = `ACT_RISING_SLOPE,
    falling_slope_mode= `ACT_FALLING_SLOPE
  } action_e;
  typedef enum logic [1:0] {
    st_idle    = 2'b01,
    st_active  = 2'b10
  } alarm_state_e;
endpackage : alarm_pkg
`default_nettype wire

/* hdl/slope_history.sv */
// Purpose: ring of past input samples for slope measurement
// Assumes: one write per scan, read of the entry one slope window back
// Notes:   read data come out of a register
`default_nettype none
module slope_history #(
  parameter int W     = 16,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic          mclk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data
);
  logic [W-1:0] mem [DEPTH];
  // ====================================================
  // write port and registered read port
  always_ff @(posedge mclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : slope_history
`default_nettype wire

/* hdl/limit_alarm_evaluator.sv */
// Purpose: one alarm channel, evaluated once per scan cycle
// Assumes: signed inputs in engineering units, scan_tick is a one-cycle enable
// Notes:   slope measured over a window of scans; pulse lasts one scan
`default_nettype none
`include "alarm_params.svh"
module limit_alarm_evaluator
  import alarm_pkg::*;
#(
  parameter int W          = 16,
  parameter int DW         = 16,
  parameter int SCAN_HZ    = 2,
  parameter int HIST_DEPTH = 64,
  parameter int HIST_AW    = 6
) (
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic          scan_tick,
  input  wire logic [3:0]    action,
  input  wire logic [W-1:0]  input_value,
  input  wire logic [W-1:0]  set_point,
  input  wire logic [W-1:0]  compare_point,
  input  wire logic [W-1:0]  hysteresis,
  input  wire logic [DW-1:0] delay_scans,
  input  wire logic          freeze_input,
  output logic               alarm_active,
  output logic               alarm_pulse
);
  // slope window in scans, capped by the history depth
  localparam int WIN_RAW   = `SLOPE_WINDOW_S * SCAN_HZ;
  localparam int WIN_SCANS = (WIN_RAW > HIST_DEPTH - 1) ? HIST_DEPTH - 1
                           : ((WIN_RAW < 1) ? 1 : WIN_RAW);
  localparam int XW = W + 2;

  // ====================================================
  // arithmetic helpers
  function automatic logic signed [XW-1:0] ext(input logic [W-1:0] v);
    ext = XW'($signed(v));
  endfunction : ext

  function automatic logic signed [XW-1:0] mag(input logic signed [XW-1:0] v);
    mag = v[XW-1] ? -v : v;
  endfunction : mag

  // ====================================================
  // two-flop synchroniser for the asynchronous freeze pin
  logic freeze_m_r;
  logic freeze_r;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      freeze_m_r <= 1'b0;
      freeze_r   <= 1'b0;
    end
    else
    begin
      freeze_m_r <= freeze_input;
      freeze_r   <= freeze_m_r;
    end
  end

  // ====================================================
  // history of samples for slope
  logic [HIST_AW-1:0] wr_ptr_r;
  logic [HIST_AW-1:0] rd_ptr;
  logic [W-1:0]       old_sample;
  logic [HIST_AW:0]   fill_r;
  logic               eval;

  assign eval   = scan_tick & ~freeze_r;
  // registered read settles between ticks, so the entry read is a full window back
  assign rd_ptr = wr_ptr_r - HIST_AW'(WIN_SCANS);

  slope_history #(
    .W     (W),
    .DEPTH (HIST_DEPTH),
    .AW    (HIST_AW)
  ) u_hist (
    .mclk    (mclk),
    .wr_en   (eval),
    .wr_addr (wr_ptr_r),
    .wr_data (input_value),
    .rd_addr (rd_ptr),
    .rd_data (old_sample)
  );

  // write pointer and fill level
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wr_ptr_r <= '0;
      fill_r   <= '0;
    end
    else if (eval)
    begin
      wr_ptr_r <= wr_ptr_r + HIST_AW'(1);
      if (fill_r < (HIST_AW+1)'(WIN_SCANS))
      begin
        fill_r <= fill_r + (HIST_AW+1)'(1);
      end
    end
  end

  // ====================================================
  // condition evaluation
  logic signed [XW-1:0] x;
  logic signed [XW-1:0] sp;
  logic signed [XW-1:0] hy;
  logic signed [XW-1:0] dev;
  logic signed [XW-1:0] slope_lim;
  logic signed [XW-1:0] delta;
  logic signed [XW+7:0] scaled;
  logic                 slope_ok;
  logic                 set_cond;
  logic                 clr_cond;
  logic                 active_r;

  assign x        = ext(input_value);
  assign sp       = ext(set_point);
  assign hy       = ext(hysteresis);
  assign dev      = x - ext(compare_point);
  assign slope_lim = mag(sp);
  assign delta    = x - ext(old_sample);
  assign slope_ok = (fill_r >= (HIST_AW+1)'(WIN_SCANS));
  // change over window scaled to per-minute units
  assign scaled   = (XW+8)'(delta) * (XW+8)'(`SECONDS_PER_MIN * SCAN_HZ)
                  - (XW+8)'(slope_lim) * (XW+8)'(WIN_SCANS);

  // raw set condition per action
  always_comb
  begin
    set_cond = 1'b0;
    unique case (action_e'(action))
      act_high:           set_cond = (x >= sp);
      act_low:            set_cond = (x <= sp);
      offset_band_mode:   set_cond = (mag(dev) >= sp);
      upper_offset_mode:  set_cond = (dev >= sp);
      lower_offset_mode:  set_cond = (-dev >= sp);
      rising_slope_mode:  set_cond = slope_ok && (delta > 0) && !scaled[XW+7];
      falling_slope_mode: set_cond = slope_ok && (delta < 0)
                                     && ((XW+8)'(-delta) * (XW+8)'(`SECONDS_PER_MIN * SCAN_HZ)
                                     >= (XW+8)'(slope_lim) * (XW+8)'(WIN_SCANS));
      default:            set_cond = 1'b0;
    endcase
  end

  // clear condition once active, with hysteresis for the level and offset actions only
  always_comb
  begin
    clr_cond = 1'b0;
    unique case (action_e'(action))
      act_high:           clr_cond = (x < sp - hy);
      act_low:            clr_cond = (x > sp + hy);
      offset_band_mode:   clr_cond = (mag(dev) < sp - hy);
      upper_offset_mode:  clr_cond = (dev < sp - hy);
      lower_offset_mode:  clr_cond = (-dev < sp - hy);
      rising_slope_mode,
      falling_slope_mode: clr_cond = !set_cond;
      default:            clr_cond = 1'b1;
    endcase
  end

  // ====================================================
  // qualification delay in whole scans
  logic [DW-1:0] qual_r;
  logic          qualified;
  assign qualified = set_cond && (qual_r >= delay_scans);

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      qual_r <= '0;
    end
    else if (eval)
    begin
      if (!set_cond || active_r)
      begin
        qual_r <= '0;
      end
      else if (qual_r != '1)
      begin
        qual_r <= qual_r + DW'(1);
      end
    end
  end

  // ====================================================
  // alarm state and pulse
  alarm_state_e state_r;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_r     <= st_idle;
      alarm_pulse <= 1'b0;
    end
    else if (eval)
    begin
      alarm_pulse <= 1'b0;
      unique case (state_r)
        st_idle:
        begin
          if (qualified)
          begin
            state_r     <= st_active;
            alarm_pulse <= 1'b1;
          end
        end
        st_active:
        begin
          if (clr_cond)
          begin
            state_r <= st_idle;
          end
        end
        default: state_r <= st_idle;
      endcase
    end
    else if (scan_tick)
    begin
      alarm_pulse <= 1'b0;  // frozen scan ends any pulse, state held
    end
  end

  assign active_r     = (state_r == st_active);
  assign alarm_active = active_r;
endmodule : limit_alarm_evaluator
`default_nettype wire

/* tb/alarm_monitor.sv */
// Purpose: port checks for the alarm evaluator
// Assumes: one clock, sync reset
// Notes:   freeze counts as settled after 4 equal samples, 3 stored plus the live pin
`default_nettype none
// ==========
// checker
module alarm_monitor #(
  parameter int W  = 16,
  parameter int DW = 16
) (
  input wire logic          mclk,
  input wire logic          rst,
  input wire logic          scan_tick,
  input wire logic [3:0]    action,
  input wire logic [W-1:0]  input_value,
  input wire logic [W-1:0]  set_point,
  input wire logic [W-1:0]  compare_point,
  input wire logic [W-1:0]  hysteresis,
  input wire logic [DW-1:0] delay_scans,
  input wire logic          freeze_input,
  input wire logic          alarm_active,
  input wire logic          alarm_pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] frz_r;
  logic       calm;
  logic       held;
  logic       go;
  logic signed [17:0] dev_m;
  logic signed [17:0] dev_abs;
  // pin history, covers the sync lag
  always_ff @(posedge mclk)
  begin
    frz_r <= {frz_r[1:0], freeze_input};
  end
  assign calm = (frz_r == 3'h0) & ~freeze_input;
  assign held = (frz_r == 3'h7) & freeze_input;
  assign go   = calm & scan_tick;
  // departure from the compare point, wide enough not to wrap
  assign dev_m   = 18'($signed(input_value)) - 18'($signed(compare_point));
  assign dev_abs = dev_m[17] ? -dev_m : dev_m;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  chk_pulse_entry: assert property ($rose(alarm_active) |-> alarm_pulse)
    else $error("alarm rose without pulse");
  chk_pulse_ends: assert property (alarm_pulse && scan_tick |=> !alarm_pulse)
    else $error("pulse outlived its scan");
  chk_tick_only: assert property (!scan_tick |=> $stable(alarm_active))
    else $error("alarm moved between scans");
  chk_none_quiet: assert property (go && action == 4'h0 |=> !alarm_active)
    else $error("alarm with no action");
  chk_high_set: assert property (go && action == 4'h1 && delay_scans == 0
    && $signed(input_value) >= $signed(set_point) |=> alarm_active)
    else $error("high alarm missed");
  chk_high_keep: assert property (go && action == 4'h1 && alarm_active
    && $signed(input_value) >= $signed(set_point) - $signed(hysteresis) |=> alarm_active)
    else $error("high alarm cleared early");
  chk_low_set: assert property (go && action == 4'h2 && delay_scans == 0
    && $signed(input_value) <= $signed(set_point) |=> alarm_active)
    else $error("low alarm missed");
  chk_band_set: assert property (go && action == 4'h3 && delay_scans == 0
    && dev_abs >= 18'($signed(set_point)) |=> alarm_active)
    else $error("band alarm missed");
  chk_freeze_hold: assert property (held |=> $stable(alarm_active))
    else $error("alarm moved while frozen");
endmodule : alarm_monitor
`default_nettype wire

/* tb/test_limit_alarm_evaluator.sv */
// Purpose: directed scenarios for the limit alarm evaluator
// Assumes: SCAN_HZ set to 1, so the slope window is 30 scans
// Notes:   inputs change 1 ns after the rising edge
`default_nettype none
// ==========
// bench
module test_limit_alarm_evaluator import alarm_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk = 1'b0, rst = 1'b1, scan_tick = 1'b0, freeze_input = 1'b0;
  logic [3:0]  action = 4'h0;
  logic [15:0] input_value = 16'h0000, set_point = 16'h0000, compare_point = 16'h03E8;
  logic [15:0] hysteresis = 16'h0000, delay_scans = 16'h0000;
  logic        alarm_active, alarm_pulse;
  int          err_total = 0, checked = 0, cyc = 0;
  limit_alarm_evaluator #(.SCAN_HZ(1)) DUT (.mclk(mclk), .rst(rst), .scan_tick(scan_tick),
    .action(action), .input_value(input_value), .set_point(set_point),
    .compare_point(compare_point), .hysteresis(hysteresis), .delay_scans(delay_scans),
    .freeze_input(freeze_input), .alarm_active(alarm_active), .alarm_pulse(alarm_pulse));
  always #2 mclk = ~mclk;
  task automatic finish_test();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic chk(input logic seen, input logic exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t alarm output wrong", $time);
    end
  endtask : chk
  // one scan with a new input, three cycles apart
  task automatic tick(input logic [15:0] v);
    input_value = v;
    @(posedge mclk) #1 scan_tick = 1'b1;
    @(posedge mclk) #1 scan_tick = 1'b0;
    @(posedge mclk) #1;
  endtask : tick
  task automatic st(input logic [15:0] v, input logic a, input logic p);
    tick(v);
    chk(alarm_active, a);
    chk(alarm_pulse, p);
  endtask : st
  task automatic cf(input action_e m, input logic [15:0] sp, input logic [15:0] hy, dl);
    action = m;
    set_point = sp;
    hysteresis = hy;
    delay_scans = dl;
  endtask : cf
  task automatic t_levels();
    cf(act_high, 16'h0064, 16'h000A, 16'h0000);
    st(16'h0063, 0, 0);
    st(16'h0064, 1, 1);
    st(16'h005A, 1, 0);
    st(16'h0059, 0, 0);
    cf(act_low, 16'hFFCE, 16'h000A, 16'h0000);
    st(16'hFFCF, 0, 0);
    st(16'hFFCE, 1, 1);
    st(16'hFFD8, 1, 0);
    st(16'hFFD9, 0, 0);
  endtask : t_levels
  task automatic t_band();
    cf(offset_band_mode, 16'h0014, 16'h0005, 16'h0000);
    st(16'h03FB, 0, 0);
    st(16'h03D4, 1, 1);
    st(16'h03F7, 1, 0);
    st(16'h03F6, 0, 0);
    cf(upper_offset_mode, 16'h0014, 16'h0005, 16'h0000);
    st(16'h03D4, 0, 0);
    st(16'h03FC, 1, 1);
    st(16'h03E8, 0, 0);
    cf(lower_offset_mode, 16'h0014, 16'h0005, 16'h0000);
    st(16'h03FC, 0, 0);
    st(16'h03D4, 1, 1);
    st(16'h03E8, 0, 0);
  endtask : t_band
  task automatic t_delay_freeze();
    cf(act_high, 16'h0064, 16'h0000, 16'h0002);
    st(16'h0064, 0, 0);
    st(16'h0064, 0, 0);
    st(16'h0064, 1, 1);
    st(16'h0000, 0, 0);
    st(16'h0064, 0, 0);
    st(16'h0064, 0, 0);
    st(16'h0000, 0, 0);
    st(16'h0064, 0, 0);
    cf(act_high, 16'h0064, 16'h0000, 16'h0000);
    st(16'h0064, 1, 1);
    freeze_input = 1'b1;
    repeat (3) @(posedge mclk) #1;
    st(16'h0000, 1, 0);
    st(16'h0000, 1, 0);
    freeze_input = 1'b0;
    repeat (3) @(posedge mclk) #1;
    st(16'h0064, 1, 0);
    cf(act_none, 16'h0064, 16'h0000, 16'h0000);
    st(16'h0064, 0, 0);
    st(16'h03E8, 0, 0);
  endtask : t_delay_freeze
  // ramps of 2 per scan against a rate of 60 per minute
  task automatic t_slope();
    cf(rising_slope_mode, 16'hFFC4, 16'h0000, 16'h0000);
    for (int i = 0; i < 40; i++)
      tick(16'(16'h0100 + 2 * i));
    chk(alarm_active, 1'b1);
    cf(falling_slope_mode, 16'hFFC4, 16'h0000, 16'h0000);
    for (int i = 0; i < 35; i++)
      tick(16'h014E);
    chk(alarm_active, 1'b0);
    for (int i = 0; i < 35; i++)
      tick(16'(16'h014E - 2 * i));
    chk(alarm_active, 1'b1);
    // ramp of 1 per scan sits exactly on a rate of 60 per minute
    cf(rising_slope_mode, 16'h003C, 16'h0000, 16'h0000);
    for (int i = 0; i < 35; i++)
      tick(16'(16'h0200 + i));
    chk(alarm_active, 1'b1);
  endtask : t_slope
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      finish_test();
    end
  end
  initial
  begin
    repeat (10) @(posedge mclk);
    #1 rst = 1'b0;
    t_levels();
    t_band();
    t_delay_freeze();
    t_slope();
    finish_test();
  end
endmodule : test_limit_alarm_evaluator
bind limit_alarm_evaluator alarm_monitor #(.W(W), .DW(DW)) mon (.mclk(mclk), .rst(rst),
  .scan_tick(scan_tick), .action(action), .input_value(input_value), .set_point(set_point),
  .compare_point(compare_point), .hysteresis(hysteresis), .delay_scans(delay_scans),
  .freeze_input(freeze_input), .alarm_active(alarm_active), .alarm_pulse(alarm_pulse));
`default_nettype wire
